// >>> hw/init_status_defs.vh
// constants for the initialization and status command handler
// assumes inclusion by bare name from the design file
`ifndef INIT_STATUS_DEFS_VH
`define INIT_STATUS_DEFS_VH

// ***************************
// register offsets
// ***************************
`define CFG_OFFSET          12'h000
`define STAT_OFFSET         12'h004
`define OTP_CHK_OFFSET      12'h008

// ***************************
// config register fields
// ***************************
`define CFG_PP_ADDR_LSB     0
`define CFG_PP_VALID_BIT    4
`define CFG_RES_LOW_BIT     5
`define CFG_CHECKOUT_BIT    6
`define CFG_PROP_LSB        7
`define CFG_INT_ERR_BIT     9
`define CFG_WIDTH           10
`define CFG_RESET           10'h000
`define OTP_CHK_RESET       4'h0

// ***************************
// command codes and crc
// ***************************
`define CMD_INIT            4'h0
`define CMD_STATUS          4'h1
`define CRC4_POLY           4'h3
`define CRC4_SEED           4'ha
`define BANK_VALID_MASK     4'h7

// ***************************
// timing
// ***************************
`define SYS_CLK_MHZ         40
`define BLANK_TIME_NS       50000
`define BLANK_CYCLES        ((`BLANK_TIME_NS * `SYS_CLK_MHZ + 999) / 1000)

`endif

// >>> hw/init_status_handler.v
// initialization and status request handler of a daisy-chained sensor node
// assumes a framing layer that delivers checked, decoded commands and
// marks the start of every bus transfer; software reaches config over apb
`include "init_status_defs.vh"
`timescale 1ns/10ps
`default_nettype none

module init_status_handler (
  // clock and reset
  input  wire        sys_clk,
  input  wire        nrst,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata_ff,
  output reg         pready_ff,
  output reg         pslverr_ff,
  // decoded command from framing layer
  input  wire        cmd_valid,
  input  wire        cmd_crc_ok,
  input  wire        cmd_long,
  input  wire        cmd_enhanced,
  input  wire [3:0]  cmd_code,
  input  wire [3:0]  cmd_addr,
  input  wire [7:0]  cmd_data,
  input  wire        xfer_start,
  // reply to framing layer
  output reg         rsp_valid_ff,
  output reg  [15:0] rsp_word_ff,
  output reg         rsp_long_ff,
  output reg         rsp_is_init_ff,
  output reg  [3:0]  rsp_crc_ff,
  // analog side
  input  wire        downstream_bus_node_high,
  output reg         bus_switch_ff
);

  // ***************************
  // states
  // ***************************
  localparam [3:0] ST_IDLE  = 4'b0001;
  localparam [3:0] ST_TEST  = 4'b0010;
  localparam [3:0] ST_BLANK = 4'b0100;
  localparam [3:0] ST_READY = 4'b1000;
  localparam integer BLANK_INT = `BLANK_CYCLES;
  localparam [11:0]  BLANK_CNT = BLANK_INT[11:0];

  // ***************************
  // crc over a reply word
  // ***************************
  function [3:0] crc4;
    input [15:0] word;
    integer i;
    reg [3:0] c;
    begin
      c = `CRC4_SEED;
      for (i = 15; i >= 0; i = i - 1) begin
        if (c[3] ^ word[i]) begin
          c = {c[2:0], 1'b0} ^ `CRC4_POLY;
        end else begin
          c = {c[2:0], 1'b0};
        end
      end
      crc4 = c;
    end
  endfunction

  // ***************************
  // state
  // ***************************
  reg [3:0]            state_ff;
  reg [11:0]           blank_cnt_ff;
  reg [3:0]            dev_addr_ff;
  reg                  bus_fault_flag_ff;
  reg                  otp_program_enable_ff;
  reg [1:0]            bank_ff;
  reg [7:0]            init_data_ff;
  reg [3:0]            init_addr_ff;
  reg [`CFG_WIDTH-1:0] cfg_ff;
  reg [3:0]            otp_chk_ff;
  reg                  pend_ff;
  reg [15:0]           pend_word_ff;
  reg                  pend_long_ff;
  reg                  pend_init_ff;

  wire [3:0] pp_addr        = cfg_ff[`CFG_PP_ADDR_LSB+3:`CFG_PP_ADDR_LSB];
  wire       pp_valid       = cfg_ff[`CFG_PP_VALID_BIT];
  wire       res_low        = cfg_ff[`CFG_RES_LOW_BIT];
  wire       checkout_running_flag = cfg_ff[`CFG_CHECKOUT_BIT];
  wire [1:0] property_pair  = cfg_ff[`CFG_PROP_LSB+1:`CFG_PROP_LSB];
  wire       int_err        = cfg_ff[`CFG_INT_ERR_BIT];
  wire       initialized    = (state_ff == ST_READY) | (state_ff == ST_BLANK);

  // address before init is the preprogrammed one or zero
  wire [3:0] cur_addr = initialized ? dev_addr_ff : (pp_valid ? pp_addr : 4'h0);

  // ***************************
  // command decode
  // ***************************
  wire [3:0] program_address      = init_data_ff[3:0];
  wire       switch_close_request = init_data_ff[6];
  wire [1:0] cmd_bank             = init_data_ff[5:4];

  // stray commands and reserved codes never leave a reply
  wire good_cmd = cmd_valid & cmd_crc_ok;
  wire init_take = good_cmd & (cmd_code == `CMD_INIT) & cmd_long & ~cmd_enhanced
                   & (state_ff == ST_IDLE);
  // status request is blind to data bits beyond the crc
  wire stat_take = good_cmd & (cmd_code == `CMD_STATUS) & (state_ff == ST_READY)
                   & (cur_addr != 4'h0) & (cmd_addr == cur_addr);

  // both addressing cases are checked together with the bank pair
  wire addr_ok = pp_valid ? ((init_addr_ff == pp_addr) & (program_address == pp_addr))
                          : ((init_addr_ff == 4'h0) & (program_address != 4'h0));
  wire [3:0] bank_mask = `BANK_VALID_MASK >> cmd_bank;
  wire       bank_ok   = bank_mask[0];
  wire       init_ok   = addr_ok & bank_ok;

  // ***************************
  // reply words
  // ***************************
  wire [7:0]  stat_low  = {otp_program_enable_ff, res_low, checkout_running_flag, bus_switch_ff,
                           property_pair, int_err, 1'b0};
  wire [15:0] stat_word = cmd_long ? {cur_addr, 4'h0, stat_low}
                                   : {8'h00, stat_low};
  wire        fault_now = downstream_bus_node_high;
  wire [15:0] init_word = {program_address, 3'b000, fault_now, init_data_ff[7],
                           ~fault_now & switch_close_request, cmd_bank, program_address};

  // otp image checked with the address field forced to zero
  wire [15:0] otp_image = {6'h00, cfg_ff[`CFG_WIDTH-1:`CFG_PP_VALID_BIT], 4'h0};
  wire [3:0]  otp_calc  = crc4(otp_image);
  wire        otp_error = otp_calc != otp_chk_ff;

  // ***************************
  // init sequence and replies
  // ***************************
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_ff              <= ST_IDLE;
      blank_cnt_ff          <= 12'h000;
      dev_addr_ff           <= 4'h0;
      bus_fault_flag_ff     <= 1'b0;
      otp_program_enable_ff <= 1'b0;
      bank_ff               <= 2'b00;
      init_data_ff          <= 8'h00;
      init_addr_ff          <= 4'h0;
      bus_switch_ff         <= 1'b0;
      pend_ff               <= 1'b0;
      pend_word_ff          <= 16'h0000;
      pend_long_ff          <= 1'b0;
      pend_init_ff          <= 1'b0;
      rsp_valid_ff          <= 1'b0;
      rsp_word_ff           <= 16'h0000;
      rsp_long_ff           <= 1'b0;
      rsp_is_init_ff        <= 1'b0;
      rsp_crc_ff            <= 4'h0;
    end else begin
      rsp_valid_ff <= 1'b0;
      // a held reply goes out once at the next transfer start
      if (xfer_start && pend_ff) begin
        rsp_valid_ff   <= 1'b1;
        rsp_word_ff    <= pend_word_ff;
        rsp_long_ff    <= pend_long_ff;
        rsp_is_init_ff <= pend_init_ff;
        rsp_crc_ff     <= pend_init_ff ? crc4(pend_word_ff) : 4'h0;
        pend_ff        <= 1'b0;
      end
      case (state_ff)
        ST_IDLE: begin
          if (init_take) begin
            init_data_ff <= cmd_data;
            init_addr_ff <= cmd_addr;
            state_ff     <= ST_TEST;
          end
        end
        ST_TEST: begin
          bus_fault_flag_ff <= fault_now;
          if (init_ok) begin
            dev_addr_ff           <= program_address;
            otp_program_enable_ff <= init_data_ff[7];
            bank_ff               <= cmd_bank;
            pend_ff               <= 1'b1;
            pend_word_ff          <= init_word;
            pend_long_ff          <= 1'b1;
            pend_init_ff          <= 1'b1;
            if (!fault_now && switch_close_request) begin
              bus_switch_ff <= 1'b1;
              blank_cnt_ff  <= BLANK_CNT;
              state_ff      <= ST_BLANK;
            end else begin
              state_ff <= ST_READY;
            end
          end else begin
            // switch stays open and no reply is queued
            state_ff <= ST_IDLE;
          end
        end
        ST_BLANK: begin
          // commands are dropped while the bus voltage recovers
          if (blank_cnt_ff <= 12'h001) begin
            state_ff <= ST_READY;
          end else begin
            blank_cnt_ff <= blank_cnt_ff - 12'h001;
          end
        end
        ST_READY: begin
          if (stat_take) begin
            pend_ff      <= 1'b1;
            pend_word_ff <= stat_word;
            pend_long_ff <= cmd_long;
            pend_init_ff <= 1'b0;
          end
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  // ***************************
  // apb slave
  // ***************************
  // answer comes in the first access cycle, never stretched
  wire setup  = psel & ~penable;
  wire access = psel & penable & pready_ff;
  wire hit_cfg  = paddr == `CFG_OFFSET;
  wire hit_stat = paddr == `STAT_OFFSET;
  wire hit_chk  = paddr == `OTP_CHK_OFFSET;

  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cfg_ff     <= `CFG_RESET;
      otp_chk_ff <= `OTP_CHK_RESET;
      prdata_ff  <= 32'h00000000;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff  <= setup;
      pslverr_ff <= setup & ~(hit_cfg | hit_stat | hit_chk);
      if (setup) begin
        if (hit_cfg) begin
          prdata_ff <= {22'h000000, cfg_ff};
        end else if (hit_stat) begin
          prdata_ff <= {19'h00000, otp_error, pend_ff, state_ff == ST_BLANK, bank_ff,
                        otp_program_enable_ff, bus_switch_ff, bus_fault_flag_ff,
                        initialized, cur_addr};
        end else if (hit_chk) begin
          prdata_ff <= {24'h000000, otp_calc, otp_chk_ff};
        end else begin
          prdata_ff <= 32'h00000000;
        end
      end
      if (access && pwrite && hit_cfg) begin
        cfg_ff <= pwdata[`CFG_WIDTH-1:0];
      end
      if (access && pwrite && hit_chk) begin
        otp_chk_ff <= pwdata[3:0];
      end
    end
  end

endmodule // init_status_handler

`default_nettype wire

// >>> testbench/init_status_props.sv
// checker for the init and status handler
// assumes it is bound onto init_status_handler
`timescale 1ns/10ps
`default_nettype none
module init_status_props (
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        nrst,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready_ff,
  input wire logic        pslverr_ff,
  // command, reply, switch
  input wire logic        xfer_start,
  input wire logic        rsp_valid_ff,
  input wire logic        rsp_long_ff,
  input wire logic        rsp_is_init_ff,
  input wire logic [15:0] rsp_word_ff,
  input wire logic        downstream_bus_node_high,
  input wire logic        bus_switch_ff
);
  // ***************************
  // properties
  // ***************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  sequence s_setup; psel && !penable; endsequence
  sequence s_init_rsp; rsp_valid_ff && rsp_is_init_ff; endsequence
  sequence s_stat_rsp; rsp_valid_ff && !rsp_is_init_ff; endsequence
  AST_PREADY_SETUP: assert property (s_setup |=> pready_ff)
    else $error("no ready after setup");
  AST_PREADY_PULSE: assert property (pready_ff |=> !pready_ff)
    else $error("ready longer than one cycle");
  AST_SLVERR_READY: assert property (pslverr_ff |-> pready_ff)
    else $error("error without ready");
  AST_SWITCH_FAULT: assert property ($rose(bus_switch_ff) |-> !$past(downstream_bus_node_high))
    else $error("switch closed on fault");
  AST_SWITCH_HOLD: assert property (bus_switch_ff |=> bus_switch_ff)
    else $error("switch opened");
  AST_RSP_AFTER_XFER: assert property (rsp_valid_ff |-> $past(xfer_start))
    else $error("reply without transfer");
  AST_RSP_ONCE: assert property (rsp_valid_ff |=> !rsp_valid_ff)
    else $error("reply repeated");
  AST_INIT_LAYOUT: assert property (s_init_rsp |-> rsp_long_ff && rsp_word_ff[11:9] == 3'h0
    && rsp_word_ff[15:12] == rsp_word_ff[3:0] && rsp_word_ff[3:0] != 4'h0)
    else $error("bad init reply");
  AST_SHORT_LAYOUT: assert property (s_stat_rsp and !rsp_long_ff
    |-> rsp_word_ff[15:8] == 8'h00 && !rsp_word_ff[0]) else $error("bad short reply");
  AST_LONG_LAYOUT: assert property (s_stat_rsp and rsp_long_ff |-> rsp_word_ff[11:8] == 4'h0
    && rsp_word_ff[15:12] != 4'h0 && !rsp_word_ff[0]) else $error("bad long reply");
endmodule // init_status_props
bind init_status_handler init_status_props props_u (.sys_clk, .nrst, .psel, .penable,
  .pready_ff, .pslverr_ff, .xfer_start, .rsp_valid_ff, .rsp_long_ff, .rsp_is_init_ff,
  .rsp_word_ff, .downstream_bus_node_high, .bus_switch_ff);
`default_nettype wire

// >>> testbench/dsi_master_model.sv
// bus master model: issues decoded commands and transfer starts
// assumes the handler samples on the rising sys_clk edge
`timescale 1ns/10ps
`default_nettype none
module dsi_master_model (
  // clock
  input  wire logic        sys_clk,
  // commands
  output var  logic        cmd_valid,
  output var  logic        cmd_crc_ok,
  output var  logic        cmd_long,
  output var  logic        cmd_enhanced,
  output var  logic [3:0]  cmd_code,
  output var  logic [3:0]  cmd_addr,
  output var  logic [7:0]  cmd_data,
  output var  logic        xfer_start,
  // replies
  input  wire logic        rsp_valid_ff,
  input  wire logic        rsp_long_ff,
  input  wire logic [15:0] rsp_word_ff
);
  // ***************************
  // transfers
  // ***************************
  initial begin
    {cmd_valid, cmd_crc_ok, cmd_long, cmd_enhanced, xfer_start} = 5'h00;
    {cmd_code, cmd_addr, cmd_data} = 16'h0000;
  end
  // address fields go out as asked, so good and bad init forms can be made
  task automatic send(input logic [3:0] c, input logic [3:0] a, input logic [7:0] d,
                      input logic l, input logic e, input logic ok);
    @(posedge sys_clk);
    {cmd_valid, cmd_crc_ok, cmd_long, cmd_enhanced} <= {1'b1, ok, l, e};
    {cmd_code, cmd_addr, cmd_data} <= {c, a, d};
    @(posedge sys_clk);
    cmd_valid <= 1'b0;
    // released fields flip so stale values never look valid
    {cmd_code, cmd_addr, cmd_data} <= ~{c, a, d};
  endtask
  task automatic xfer(output logic got, output logic [15:0] w, output logic l);
    {got, w, l} = 18'h0;
    @(posedge sys_clk);
    xfer_start <= 1'b1;
    @(posedge sys_clk);
    xfer_start <= 1'b0;
    repeat (3) begin
      @(posedge sys_clk);
      if (rsp_valid_ff === 1'b1) begin
        {got, w, l} = {1'b1, rsp_word_ff, rsp_long_ff};
      end
    end
  endtask
endmodule // dsi_master_model
`default_nettype wire

// >>> testbench/dsi_init_status_handler_bench.sv
// bench for the init and status handler
// assumes the model and checker are compiled first, hw/ on include path
`include "init_status_defs.vh"
`timescale 1ns/10ps
`default_nettype none
module dsi_init_status_handler_bench;
  // ***************************
  // signals and instances
  // ***************************
  logic        sys_clk, nrst, psel, penable, pwrite, pready_ff, pslverr_ff, got, lng, err;
  logic        cmd_valid, cmd_crc_ok, cmd_long, cmd_enhanced, xfer_start, bus_switch_ff;
  logic        rsp_valid_ff, rsp_long_ff, rsp_is_init_ff, downstream_bus_node_high;
  logic [3:0]  cmd_code, cmd_addr, rsp_crc_ff;
  logic [7:0]  cmd_data;
  logic [11:0] paddr;
  logic [15:0] rsp_word_ff, w;
  logic [31:0] pwdata, prdata_ff, r;
  int          n_errors, comparisons, cycles;
  // {addr, data, long, fault, reply, 0}
  localparam logic [15:0] CS [6] = '{16'h3458, 16'h0408, 16'h0758, 16'h0450, 16'h045e, 16'h0c5a};
  // {code, addr, crc ok}
  localparam logic [8:0]  RF [4] = '{9'h02d, 9'h02a, 9'h06b, 9'h001};
  init_status_handler dut_u (.sys_clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata_ff, .pready_ff, .pslverr_ff, .cmd_valid, .cmd_crc_ok, .cmd_long, .cmd_enhanced,
    .cmd_code, .cmd_addr, .cmd_data, .xfer_start, .rsp_valid_ff, .rsp_word_ff, .rsp_long_ff,
    .rsp_is_init_ff, .rsp_crc_ff, .downstream_bus_node_high, .bus_switch_ff);
  dsi_master_model master_u (.sys_clk, .cmd_valid, .cmd_crc_ok, .cmd_long, .cmd_enhanced,
    .cmd_code, .cmd_addr, .cmd_data, .xfer_start, .rsp_valid_ff, .rsp_long_ff, .rsp_word_ff);
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors = n_errors + 1;
      tally_and_finish();
    end
  end
  // ***************************
  // tasks
  // ***************************
  task automatic chk(input logic ok, input string m);
    comparisons++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("ERROR at %0t: %s", $time, m);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready_ff !== 1'b1);
    {r, err} = {prdata_ff, pslverr_ff};
    {psel, penable} <= 2'b00;
  endtask
  task automatic do_reset;
    nrst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    nrst <= 1'b1;
  endtask
  task automatic t_regs;
    do_reset();
    apb(1'b0, `CFG_OFFSET, 32'h0);
    chk(r === 32'h0 && err === 1'b0, "cfg reset");
    apb(1'b0, `STAT_OFFSET, 32'h0);
    chk(r[11:0] === 12'h000, "stat reset");
    master_u.send(`CMD_STATUS, 4'h0, 8'h00, 1'b1, 1'b0, 1'b1);
    master_u.xfer(got, w, lng);
    chk(got === 1'b0, "status at address zero");
    apb(1'b0, 12'h0fc, 32'h0);
    chk(err === 1'b1 && r === 32'h0, "unmapped");
    apb(1'b1, `CFG_OFFSET, 32'hffff_ffff);
    apb(1'b0, `CFG_OFFSET, 32'h0);
    chk(r === 32'h3ff, "cfg readback");
    $display("register test done");
  endtask
  task automatic t_init;
    logic [15:0] c;
    logic [15:0] m;
    for (int i = 0; i < 6; i++) begin
      c = CS[i];
      // requested switch bit is moot when the test fails
      m = c[2] ? 16'hffbf : 16'hffff;
      do_reset();
      apb(1'b1, `CFG_OFFSET, 32'h320);
      downstream_bus_node_high <= c[2];
      master_u.send(`CMD_INIT, c[15:12], c[11:4], c[3], 1'b0, 1'b1);
      repeat (3) @(posedge sys_clk);
      master_u.xfer(got, w, lng);
      chk(got === c[1], "init reply presence");
      chk(!c[1] || (w & m) === ({c[7:4], 3'h0, c[2], c[11:4]} & m), "init word");
      chk(bus_switch_ff === (c[1] & ~c[2] & c[10]), "switch");
      downstream_bus_node_high <= 1'b0;
    end
    $display("init test done");
  endtask
  task automatic t_status;
    master_u.send(`CMD_STATUS, 4'h5, 8'h00, 1'b1, 1'b0, 1'b1);
    master_u.xfer(got, w, lng);
    chk(got === 1'b0, "status in blanking");
    repeat (`BLANK_CYCLES) @(posedge sys_clk);
    for (int j = 0; j < 4; j++) begin
      master_u.send(`CMD_STATUS, 4'h5, 8'h3c << j, j[1], j[0], 1'b1);
      master_u.xfer(got, w, lng);
      chk(got === 1'b1 && lng === j[1], "status reply");
      chk(w === (j[1] ? 16'h50da : 16'h00da), "status word");
      chk(rsp_is_init_ff === 1'b0 && rsp_crc_ff === 4'h0, "status reply kind");
    end
    for (int k = 0; k < 4; k++) begin
      master_u.send(RF[k][8:5], RF[k][4:1], 8'h46, 1'b1, 1'b0, RF[k][0]);
      repeat (2) @(posedge sys_clk);
      master_u.xfer(got, w, lng);
      chk(got === 1'b0, "refused command");
    end
    apb(1'b0, `STAT_OFFSET, 32'h0);
    chk(r[7:0] === 8'hd5 && err === 1'b0, "stat after init");
    $display("status test done");
  endtask
  task automatic tally_and_finish;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    {psel, penable, pwrite, nrst, downstream_bus_node_high} = 5'h00;
    {paddr, pwdata} = 44'h0;
    {n_errors, comparisons, cycles} = 96'h0;
    t_regs();
    t_init();
    t_status();
    tally_and_finish();
  end
endmodule // dsi_init_status_handler_bench
`default_nettype wire
